// ===== hdl/sdl_pkg.sv
// Constants for the single-wire debug link target controller
// Assumes one system clock and an alternate debug tick enable
//
// What this block does
// - MSB first, sixteen debug cycles per bit
// - Time out after 512 idle debug cycles
// - Timeout abandons command, no side effects
// - Bit start perceived within one debug cycle
// - Sample received bit ten cycles after start
// - Pin undriven during host-to-target bits
// - Sent one: high pulse at cycle seven
// - Sent zero: low thirteen cycles, then high
// - Clock select bit picks debug clock
// - Pin level at reset picks startup mode
// - Pin high at reset starts user program
// - Speed-sync request gets timed response pulse
// - Register, trace, go need halted CPU
// - Memory and status commands work always
// - Halt request wakes CPU from stop/wait
// - Oscillator on when enabled; watchdog held halted
// - One breakpoint, reached only over link
// - Eight-bit command code, sixteen-cycle delay slot

package sdl_pkg;
  // ------------------------------------------------
  // Bit timing in debug cycles
  // ------------------------------------------------
  localparam int BIT_CYC       = 16;
  localparam int SAMPLE_CYC    = 10;
  localparam int ONE_PULSE_CYC = 7;
  localparam int ZERO_LOW_CYC  = 13;
  localparam int TIMEOUT_CYC   = 512;
  localparam int SYNC_LOW_CYC  = 128;
  localparam int SYNC_WAIT_CYC = 16;
  localparam int SYNC_RESP_CYC = 128;
  // ------------------------------------------------
  // Command codes
  // ------------------------------------------------
  localparam logic [7:0] CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] CMD_RD_STATUS  = 8'hE4;
  localparam logic [7:0] CMD_WR_CONTROL = 8'hC4;
  localparam logic [7:0] CMD_RD_BYTE    = 8'hE0;
  localparam logic [7:0] CMD_WR_BYTE    = 8'hC0;
  localparam logic [7:0] CMD_RD_BKPT    = 8'hE2;
  localparam logic [7:0] CMD_WR_BKPT    = 8'hC2;
  localparam logic [7:0] CMD_GO         = 8'h08;
  localparam logic [7:0] CMD_STEP       = 8'h10;
  localparam logic [7:0] CMD_RD_ACC     = 8'h68;
  localparam logic [7:0] CMD_WR_ACC     = 8'h48;
  // ------------------------------------------------
  // Status and control byte
  // ------------------------------------------------
  localparam int         CTL_ENABLE_BIT = 7;
  localparam int         CTL_HALTED_BIT = 6;
  localparam int         CTL_BKEN_BIT   = 5;
  localparam int         CTL_CLKSEL_BIT = 2;
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] CTL_WR_MASK    = 8'hA4;

  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WDATA, ST_MRD, ST_TX} sdl_state_e;
endpackage

// ===== hdl/sdl_debug_link.sv
// Target side of the single-wire debug link
// Assumes memory read data valid in the same cycle as mem_rd_o
`timescale 1ns/100ps
module sdl_debug_link
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        alt_tick_i,
  // Debug pin
  input  wire logic        debug_pin_i,
  output logic             debug_pin_o,
  output logic             debug_pin_oe_o,
  // Memory access
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_wr_o,
  output logic             mem_rd_o,
  input  wire logic [7:0]  mem_rdata_i,
  // CPU register access
  input  wire logic [7:0]  cpu_acc_i,
  output logic [7:0]       cpu_acc_o,
  output logic             cpu_acc_wr_o,
  input  wire logic        cpu_fetch_i,
  input  wire logic [15:0] cpu_fetch_addr_i,
  // CPU control
  output logic             halted_o,
  output logic             go_o,
  output logic             step_o,
  output logic             wake_o,
  output logic             osc_keep_o,
  output logic             wdog_hold_o
);
  // ------------------------------------------------
  // Declarations
  // ------------------------------------------------
  logic                 pin_s1_q;
  logic                 pin_s2_q;
  logic                 pin_s3_q;
  logic                 fall;
  logic                 fall_pend_q;
  logic                 tick;
  logic                 start;
  logic                 tx_mode;
  logic                 bit_act_q;
  logic                 tx_act_q;
  logic                 tx_bit_q;
  logic [4:0]           cnt_q;
  logic [4:0]           cnt_nx;
  logic                 rx_bit;
  logic                 tx_done;
  logic [9:0]           idle_q;
  logic                 timeout;
  logic [7:0]           low_q;
  logic                 sync_seen_q;
  logic                 resp_act_q;
  logic [8:0]           resp_q;
  logic                 sync_go;
  logic                 abort;
  logic                 rst_d_q;
  logic                 release_p;
  sdl_pkg::sdl_state_e  fsm_q;
  logic [7:0]           cmd_q;
  logic [4:0]           need_q;
  logic [4:0]           rx_n_q;
  logic [15:0]          rx_sr_q;
  logic [15:0]          rx_nv;
  logic [15:0]          tx_sr_q;
  logic [4:0]           tx_n_q;
  logic [7:0]           ctl_q;
  logic [15:0]          bkpt_q;
  logic                 halted_q;
  logic                 bk_hit;
  logic [7:0]           status;

  // ------------------------------------------------
  // Pin synchroniser and edge detect
  // ------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    pin_s1_q <= debug_pin_i;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  assign fall = pin_s3_q & ~pin_s2_q;
  assign tick = ctl_q[sdl_pkg::CTL_CLKSEL_BIT] ? alt_tick_i : 1'b1;
  assign start = tick & fall_pend_q & ~resp_act_q;
  assign tx_mode = (fsm_q == sdl_pkg::ST_TX);
  assign cnt_nx = cnt_q + 5'd1;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      fall_pend_q <= 1'b0;
    else
      fall_pend_q <= fall | (fall_pend_q & ~tick);
  end

  // ------------------------------------------------
  // Bit engine and pin drive
  // ------------------------------------------------
  assign rx_bit = tick & bit_act_q & ~tx_act_q
                  & (cnt_q == 5'(sdl_pkg::SAMPLE_CYC));
  assign tx_done = tick & bit_act_q & tx_act_q
                   & (cnt_q == 5'(sdl_pkg::BIT_CYC - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      bit_act_q      <= 1'b0;
      tx_act_q       <= 1'b0;
      tx_bit_q       <= 1'b0;
      cnt_q          <= 5'h00;
      debug_pin_oe_o <= 1'b0;
      debug_pin_o    <= 1'b0;
    end
    else if (resp_act_q)
    begin
      bit_act_q      <= 1'b0;
      debug_pin_oe_o <= (resp_q >= 9'(sdl_pkg::SYNC_WAIT_CYC));
      debug_pin_o    <= (resp_q == 9'(sdl_pkg::SYNC_WAIT_CYC + sdl_pkg::SYNC_RESP_CYC));
    end
    else if (start)
    begin
      bit_act_q      <= 1'b1;
      tx_act_q       <= tx_mode;
      tx_bit_q       <= tx_sr_q[15];
      cnt_q          <= 5'h00;
      debug_pin_oe_o <= tx_mode & ~tx_sr_q[15];
      debug_pin_o    <= 1'b0;
    end
    else if (tick && bit_act_q)
    begin
      cnt_q <= cnt_nx;
      if (cnt_q == 5'(sdl_pkg::BIT_CYC - 1))
        bit_act_q <= 1'b0;
      if (!tx_act_q)
      begin
        debug_pin_oe_o <= 1'b0;
        debug_pin_o    <= 1'b0;
      end
      else if (tx_bit_q)
      begin
        debug_pin_oe_o <= (cnt_nx == 5'(sdl_pkg::ONE_PULSE_CYC));
        debug_pin_o    <= (cnt_nx == 5'(sdl_pkg::ONE_PULSE_CYC));
      end
      else
      begin
        debug_pin_oe_o <= (cnt_nx <= 5'(sdl_pkg::ZERO_LOW_CYC));
        debug_pin_o    <= (cnt_nx == 5'(sdl_pkg::ZERO_LOW_CYC));
      end
    end
    else if (tick)
    begin
      debug_pin_oe_o <= 1'b0;
      debug_pin_o    <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Idle timeout
  // ------------------------------------------------
  assign timeout = tick & ~start & (idle_q == 10'(sdl_pkg::TIMEOUT_CYC - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      idle_q <= 10'h000;
    else if (start)
      idle_q <= 10'h000;
    else if (tick && idle_q != 10'(sdl_pkg::TIMEOUT_CYC))
      idle_q <= idle_q + 10'h001;
  end

  // ------------------------------------------------
  // Speed-sync detect and response
  // ------------------------------------------------
  assign sync_go = tick & sync_seen_q & pin_s2_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      low_q       <= 8'h00;
      sync_seen_q <= 1'b0;
      resp_act_q  <= 1'b0;
      resp_q      <= 9'h000;
    end
    else if (resp_act_q)
    begin
      if (tick)
        resp_q <= resp_q + 9'h001;
      if (tick && resp_q == 9'(sdl_pkg::SYNC_WAIT_CYC + sdl_pkg::SYNC_RESP_CYC))
        resp_act_q <= 1'b0;
    end
    else if (sync_go)
    begin
      sync_seen_q <= 1'b0;
      resp_act_q  <= 1'b1;
      resp_q      <= 9'h000;
      low_q       <= 8'h00;
    end
    else if (tick)
    begin
      if (pin_s2_q || debug_pin_oe_o)
        low_q <= 8'h00;
      else if (low_q != 8'(sdl_pkg::SYNC_LOW_CYC - 1))
        low_q <= low_q + 8'h01;
      else
        sync_seen_q <= 1'b1;
    end
  end

  // ------------------------------------------------
  // Command sequencer
  // ------------------------------------------------
  assign abort = timeout | sync_go;
  assign rx_nv = {rx_sr_q[14:0], pin_s2_q};
  assign release_p = rst_d_q & ~srst_i;
  assign bk_hit = ctl_q[sdl_pkg::CTL_BKEN_BIT] & cpu_fetch_i
                  & (cpu_fetch_addr_i == bkpt_q) & ~halted_q;
  assign status = (ctl_q & sdl_pkg::CTL_WR_MASK)
                  | ({7'h00, halted_q} << sdl_pkg::CTL_HALTED_BIT);

  always_ff @(posedge clk_sys_i)
  begin
    rst_d_q <= srst_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      fsm_q        <= sdl_pkg::ST_CMD;
      cmd_q        <= 8'h00;
      need_q       <= 5'd8;
      rx_n_q       <= 5'h00;
      rx_sr_q      <= 16'h0000;
      tx_sr_q      <= 16'h0000;
      tx_n_q       <= 5'h00;
      ctl_q        <= sdl_pkg::CTL_RESET;
      bkpt_q       <= 16'h0000;
      halted_q     <= 1'b0;
      mem_addr_o   <= 16'h0000;
      mem_wdata_o  <= 8'h00;
      mem_wr_o     <= 1'b0;
      mem_rd_o     <= 1'b0;
      cpu_acc_o    <= 8'h00;
      cpu_acc_wr_o <= 1'b0;
      go_o         <= 1'b0;
      step_o       <= 1'b0;
      wake_o       <= 1'b0;
    end
    else
    begin
      mem_wr_o     <= 1'b0;
      mem_rd_o     <= 1'b0;
      cpu_acc_wr_o <= 1'b0;
      go_o         <= 1'b0;
      step_o       <= 1'b0;
      wake_o       <= 1'b0;
      if (release_p && !pin_s2_q)
      begin
        halted_q                        <= 1'b1;
        ctl_q[sdl_pkg::CTL_ENABLE_BIT]  <= 1'b1;
      end
      else if (bk_hit)
        halted_q <= 1'b1;
      if (abort)
      begin
        fsm_q  <= sdl_pkg::ST_CMD;
        need_q <= 5'd8;
        rx_n_q <= 5'h00;
        tx_n_q <= 5'h00;
      end
      else if (fsm_q == sdl_pkg::ST_MRD)
      begin
        tx_sr_q <= {mem_rdata_i, 8'h00};
        tx_n_q  <= 5'd8;
        fsm_q   <= sdl_pkg::ST_TX;
      end
      else if (tx_done)
      begin
        tx_sr_q <= {tx_sr_q[14:0], 1'b0};
        tx_n_q  <= tx_n_q - 5'd1;
        if (tx_n_q == 5'd1)
          fsm_q <= sdl_pkg::ST_CMD;
      end
      else if (rx_bit && rx_n_q != need_q - 5'd1)
      begin
        rx_sr_q <= rx_nv;
        rx_n_q  <= rx_n_q + 5'd1;
      end
      else if (rx_bit)
      begin
        rx_sr_q <= rx_nv;
        rx_n_q  <= 5'h00;
        case (fsm_q)
          sdl_pkg::ST_CMD:
          begin
            cmd_q <= rx_nv[7:0];
            case (rx_nv[7:0])
              sdl_pkg::CMD_BACKGROUND:
                if (ctl_q[sdl_pkg::CTL_ENABLE_BIT])
                begin
                  halted_q <= 1'b1;
                  wake_o   <= 1'b1;
                end
              sdl_pkg::CMD_RD_STATUS:
              begin
                tx_sr_q <= {status, 8'h00};
                tx_n_q  <= 5'd8;
                fsm_q   <= sdl_pkg::ST_TX;
              end
              sdl_pkg::CMD_WR_CONTROL:
                fsm_q <= sdl_pkg::ST_WDATA;
              sdl_pkg::CMD_RD_BYTE, sdl_pkg::CMD_WR_BYTE:
              begin
                need_q <= 5'd16;
                fsm_q  <= sdl_pkg::ST_ADDR;
              end
              sdl_pkg::CMD_RD_BKPT:
              begin
                tx_sr_q <= bkpt_q;
                tx_n_q  <= 5'd16;
                fsm_q   <= sdl_pkg::ST_TX;
              end
              sdl_pkg::CMD_WR_BKPT:
              begin
                need_q <= 5'd16;
                fsm_q  <= sdl_pkg::ST_WDATA;
              end
              sdl_pkg::CMD_GO:
                if (halted_q)
                begin
                  halted_q <= 1'b0;
                  go_o     <= 1'b1;
                end
              sdl_pkg::CMD_STEP:
                step_o <= halted_q;
              sdl_pkg::CMD_RD_ACC:
                if (halted_q)
                begin
                  tx_sr_q <= {cpu_acc_i, 8'h00};
                  tx_n_q  <= 5'd8;
                  fsm_q   <= sdl_pkg::ST_TX;
                end
              sdl_pkg::CMD_WR_ACC:
                if (halted_q)
                  fsm_q <= sdl_pkg::ST_WDATA;
              default:
                fsm_q <= sdl_pkg::ST_CMD;
            endcase
          end
          sdl_pkg::ST_ADDR:
          begin
            mem_addr_o <= rx_nv;
            need_q     <= 5'd8;
            if (cmd_q == sdl_pkg::CMD_RD_BYTE)
            begin
              mem_rd_o <= 1'b1;
              fsm_q    <= sdl_pkg::ST_MRD;
            end
            else
              fsm_q <= sdl_pkg::ST_WDATA;
          end
          sdl_pkg::ST_WDATA:
          begin
            need_q <= 5'd8;
            fsm_q  <= sdl_pkg::ST_CMD;
            case (cmd_q)
              sdl_pkg::CMD_WR_CONTROL:
                ctl_q <= rx_nv[7:0] & sdl_pkg::CTL_WR_MASK;
              sdl_pkg::CMD_WR_BKPT:
                bkpt_q <= rx_nv;
              sdl_pkg::CMD_WR_ACC:
              begin
                cpu_acc_o    <= rx_nv[7:0];
                cpu_acc_wr_o <= 1'b1;
              end
              sdl_pkg::CMD_WR_BYTE:
              begin
                mem_wdata_o <= rx_nv[7:0];
                mem_wr_o    <= 1'b1;
              end
              default:
                fsm_q <= sdl_pkg::ST_CMD;
            endcase
          end
          default:
            fsm_q <= sdl_pkg::ST_CMD;
        endcase
      end
    end
  end

  // ------------------------------------------------
  // CPU side levels
  // ------------------------------------------------
  assign halted_o    = halted_q;
  assign osc_keep_o  = ctl_q[sdl_pkg::CTL_ENABLE_BIT];
  assign wdog_hold_o = halted_q;

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  a_start_delay: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (fall && !ctl_q[2] && !resp_act_q && !fall_pend_q) |=> ##1 (bit_act_q && cnt_q == 5'd0))
    else $error("bit start not perceived in time");
  a_sample_ten: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start && !tx_mode && !ctl_q[2] && !fall) |-> ##11 rx_bit)
    else $error("received bit not sampled at cycle ten");
  a_one_pulse: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start && tx_mode && tx_sr_q[15] && !ctl_q[2])
    |=> (!debug_pin_oe_o)[*7] ##1 (debug_pin_oe_o && debug_pin_o) ##1 !debug_pin_oe_o)
    else $error("speedup pulse for one misplaced");
  a_zero_low: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start && tx_mode && !tx_sr_q[15] && !ctl_q[2])
    |=> (debug_pin_oe_o && !debug_pin_o)[*8] ##1 (debug_pin_oe_o && !debug_pin_o)[*5]
    ##1 (debug_pin_oe_o && debug_pin_o) ##1 !debug_pin_oe_o)
    else $error("zero bit low time wrong");
  a_rx_release: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bit_act_q && !tx_act_q && !resp_act_q) |-> !debug_pin_oe_o)
    else $error("pin driven during host bit");
  a_timeout_abort: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    timeout |=> (fsm_q == sdl_pkg::ST_CMD && rx_n_q == 5'd0 && !mem_wr_o && !cpu_acc_wr_o))
    else $error("timeout did not abandon command");
  a_timeout_count: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    start |=> !timeout[*8])
    else $error("timeout too soon after bit start");
  a_strap_halt: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rst_d_q && !pin_s2_q) |=> halted_o && osc_keep_o)
    else $error("low pin at reset did not halt");
  a_strap_run: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rst_d_q && pin_s2_q) |=> !halted_o)
    else $error("high pin at reset halted cpu");
  a_go_halted: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (go_o || step_o || cpu_acc_wr_o) |-> $past(halted_q))
    else $error("active command accepted while running");
  a_bkpt_halt: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bk_hit |=> halted_o && wdog_hold_o)
    else $error("breakpoint hit did not halt");
endmodule

// ===== dv/sdl_host_pod.sv
// Debug pod model: opens every bit, sends and reads bytes, sync, strap
// Assumes the bench resolves the pulled-up pin from all drivers
`timescale 1ns/100ps
module sdl_host_pod
(
  // Clock and pin
  input  wire logic clk_sys_i,
  input  wire logic debug_pin_i,
  // Host drive
  output logic      host_o,
  output logic      host_oe_o,
  output logic      tx_act_o
);
  int per = 1;
  initial
  begin
    host_o    = 1'b1;
    host_oe_o = 1'b0;
    tx_act_o  = 1'b0;
  end
  // ----------------------------------------
  // Debug cycle delays
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n * per) @(posedge clk_sys_i);
  endtask
  // ----------------------------------------
  // Host to target, pin driven both ways
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      tx_act_o  <= 1'b1;
      host_oe_o <= 1'b1;
      host_o    <= 1'b0;
      idle(v[i] ? 4 : 16);
      host_o <= 1'b1;
      idle(v[i] ? 16 : 4);
    end
    host_oe_o <= 1'b0;
    tx_act_o  <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // ----------------------------------------
  // Target to host
  // ----------------------------------------
  task automatic recv_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      host_oe_o <= 1'b1;
      host_o    <= 1'b0;
      idle(5);
      host_oe_o <= 1'b0;
      idle(8);
      v[i] = debug_pin_i;
      idle(7);
    end
  endtask
  // ----------------------------------------
  // Sync request, measures response low time
  // ----------------------------------------
  task automatic sync(output int len);
    host_oe_o <= 1'b1;
    host_o    <= 1'b0;
    idle(140);
    host_o <= 1'b1;
    @(posedge clk_sys_i);
    host_oe_o <= 1'b0;
    len = 0;
    for (int i = 0; i < 200 && debug_pin_i; i++)
      @(posedge clk_sys_i);
    while (!debug_pin_i && len < 300)
    begin
      @(posedge clk_sys_i);
      len++;
    end
  endtask
  // ----------------------------------------
  // Hold pin low across reset
  // ----------------------------------------
  task automatic strap(input logic low);
    host_oe_o <= low;
    host_o    <= 1'b0;
  endtask
endmodule

// ===== dv/sdl_debug_link_tb.sv
// Bench for the debug link target controller
// Assumes bus clock as debug clock unless the select bit is set
`timescale 1ns/100ps
module sdl_debug_link_tb;
  logic        clk_sys_i        = 1'b0;
  logic        srst_i           = 1'b1;
  logic        alt_tick_i       = 1'b0;
  wire logic [7:0] mem_rdata_i;
  logic [7:0]  cpu_acc_i        = 8'h5B;
  logic        cpu_fetch_i      = 1'b0;
  logic [15:0] cpu_fetch_addr_i = 16'h0000;
  wire logic   debug_pin;
  wire logic        pin_o, pin_oe, host_o, host_oe, tx_act;
  wire logic [15:0] mem_addr_o;
  wire logic [7:0]  mem_wdata_o, cpu_acc_o;
  wire logic        mem_wr_o, mem_rd_o, cpu_acc_wr_o, halted_o, go_o, step_o, wake_o;
  wire logic        osc_keep_o, wdog_hold_o;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data, rb;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [15:0] n_go = 16'h0000, n_step = 16'h0000, n_wake = 16'h0000;
  logic [15:0] n_wr = 16'h0000, n_acc = 16'h0000, n_rd = 16'h0000;
  int          len;

  assign debug_pin = pin_oe ? pin_o : (host_oe ? host_o : 1'b1);
  // Memory answers from the registered address, valid when the read strobe is seen
  assign mem_rdata_i = ~mem_addr_o[7:0];
  always #5 clk_sys_i = ~clk_sys_i;

  sdl_debug_link uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .alt_tick_i(alt_tick_i),
    .debug_pin_i(debug_pin), .debug_pin_o(pin_o), .debug_pin_oe_o(pin_oe),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o),
    .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .cpu_acc_i(cpu_acc_i),
    .cpu_acc_o(cpu_acc_o), .cpu_acc_wr_o(cpu_acc_wr_o), .cpu_fetch_i(cpu_fetch_i),
    .cpu_fetch_addr_i(cpu_fetch_addr_i), .halted_o(halted_o), .go_o(go_o),
    .step_o(step_o), .wake_o(wake_o), .osc_keep_o(osc_keep_o), .wdog_hold_o(wdog_hold_o));

  sdl_host_pod pod (.clk_sys_i(clk_sys_i), .debug_pin_i(debug_pin), .host_o(host_o),
    .host_oe_o(host_oe), .tx_act_o(tx_act));

  // ----------------------------------------
  // Memory, alternate tick, pulse monitors
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    alt_tick_i  <= ~alt_tick_i;
    n_rd   += (mem_rd_o === 1'b1);
    n_go   += (go_o === 1'b1);
    n_step += (step_o === 1'b1);
    n_wake += (wake_o === 1'b1);
    n_acc  += (cpu_acc_wr_o === 1'b1);
    if (mem_wr_o === 1'b1)
    begin
      n_wr++;
      wr_addr = mem_addr_o;
      wr_data = mem_wdata_o;
    end
    if (tx_act === 1'b1)
      check(pin_oe, 16'h0000);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t value %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, input int slot);
    pod.send_byte(c);
    pod.idle(slot);
  endtask
  task automatic rd_status(input logic [7:0] e);
    cmd(sdl_pkg::CMD_RD_STATUS, 0);
    pod.recv_byte(rb);
    check(rb, e);
  endtask
  task automatic wr_ctl(input logic [7:0] v);
    cmd(sdl_pkg::CMD_WR_CONTROL, 0);
    pod.send_byte(v);
  endtask
  task automatic fetch(input logic [15:0] a);
    cpu_fetch_i      <= 1'b1;
    cpu_fetch_addr_i <= a;
    @(posedge clk_sys_i);
    cpu_fetch_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_startup();
    check(halted_o, 16'h0000);
    check(wdog_hold_o, 16'h0000);
    wr_ctl(8'h80);
    rd_status(8'h80);
    check(osc_keep_o, 16'h0001);
    cmd(sdl_pkg::CMD_GO, 16);
    cmd(sdl_pkg::CMD_RD_ACC, 16);
    cmd(8'h5A, 16);
    rd_status(8'h80);
    check(n_go, 16'h0000);
  endtask
  task automatic t_memory();
    cmd(sdl_pkg::CMD_WR_BYTE, 0);
    pod.send_byte(8'h12);
    pod.idle(400);
    pod.send_byte(8'h34);
    pod.send_byte(8'hA5);
    pod.idle(16);
    check(n_wr, 16'h0001);
    check(wr_addr, 16'h1234);
    check(wr_data, 16'h00A5);
    cmd(sdl_pkg::CMD_RD_BYTE, 0);
    pod.send_byte(8'h0F);
    pod.send_byte(8'h0F);
    pod.idle(16);
    pod.recv_byte(rb);
    check(rb, 16'h00F0);
    check(n_rd, 16'h0001);
    check(mem_addr_o, 16'h0F0F);
  endtask
  task automatic t_timeout();
    cmd(sdl_pkg::CMD_WR_BYTE, 0);
    pod.send_byte(8'h56);
    pod.idle(600);
    rd_status(8'h80);
    check(n_wr, 16'h0001);
    check(halted_o, 16'h0000);
  endtask
  task automatic t_halted();
    cmd(sdl_pkg::CMD_BACKGROUND, 16);
    check(halted_o, 16'h0001);
    check(n_wake, 16'h0001);
    check(wdog_hold_o, 16'h0001);
    cmd(sdl_pkg::CMD_WR_ACC, 0);
    pod.send_byte(8'h77);
    pod.idle(16);
    check(n_acc, 16'h0001);
    check(cpu_acc_o, 16'h0077);
    cmd(sdl_pkg::CMD_RD_ACC, 16);
    pod.recv_byte(rb);
    check(rb, 16'h005B);
    cmd(sdl_pkg::CMD_STEP, 16);
    check(n_step, 16'h0001);
    rd_status(8'hC0);
  endtask
  task automatic t_breakpoint();
    cmd(sdl_pkg::CMD_WR_BKPT, 0);
    pod.send_byte(8'h40);
    pod.send_byte(8'h00);
    cmd(sdl_pkg::CMD_RD_BKPT, 0);
    pod.recv_byte(rb);
    check(rb, 16'h0040);
    pod.recv_byte(rb);
    check(rb, 16'h0000);
    cmd(sdl_pkg::CMD_GO, 16);
    check(n_go, 16'h0001);
    check(halted_o, 16'h0000);
    wr_ctl(8'hA0);
    fetch(16'h4001);
    check(halted_o, 16'h0000);
    fetch(16'h4000);
    check(halted_o, 16'h0001);
  endtask
  task automatic t_clock_sel();
    wr_ctl(8'h84);
    pod.per = 2;
    rd_status(8'hC4);
    wr_ctl(8'h80);
    pod.per = 1;
    rd_status(8'hC0);
  endtask
  task automatic t_sync();
    pod.sync(len);
    check(16'(len), 16'(sdl_pkg::SYNC_RESP_CYC));
    pod.idle(20);
    rd_status(8'hC0);
  endtask
  task automatic t_strap();
    pod.strap(1'b1);
    srst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    pod.strap(1'b0);
    repeat (2) @(posedge clk_sys_i);
    check(halted_o, 16'h0001);
    rd_status(8'hC0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    t_startup();
    t_memory();
    t_timeout();
    t_halted();
    t_breakpoint();
    t_clock_sel();
    t_sync();
    t_strap();
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    mismatches++;
    tally_and_finish();
  end
endmodule
